// *** rtl/exec_pkg.sv ***
// constants and types shared by the instruction execute block
`default_nettype none
package exec_pkg;

  // data-space address of the working register
  localparam logic [11:0] WORK_ADDR = 12'hFE8;
  // file addresses below this value sit in the low part of the access bank
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;

  // register offsets on the bus (byte addresses)
  localparam logic [7:0] OFS_WORK = 8'h00;
  localparam logic [7:0] OFS_BANK = 8'h04;
  localparam logic [7:0] OFS_PROD_LOW = 8'h08;
  localparam logic [7:0] OFS_PROD_HIGH = 8'h0C;
  localparam logic [7:0] OFS_PTR0 = 8'h10;
  localparam logic [7:0] OFS_PTR1 = 8'h14;
  localparam logic [7:0] OFS_PTR2 = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  localparam logic [7:0] OFS_CTRL = 8'h20;
  localparam logic [7:0] OFS_EXEC = 8'h24;

  // field positions
  localparam int unsigned STATUS_Z_BIT = 0;
  localparam int unsigned STATUS_N_BIT = 1;
  localparam int unsigned CTRL_EXT_BIT = 0;

  // values after reset
  localparam logic [7:0] WORK_RST = 8'h00;
  localparam logic [3:0] BANK_RST = 4'h0;
  localparam logic [7:0] PROD_RST = 8'h00;
  localparam logic [11:0] PTR_RST = 12'h000;
  localparam logic EXT_RST = 1'h0;

  // opcode patterns
  localparam logic [7:0] OPC_OR_LIT = 8'h09;
  localparam logic [7:0] OPC_LIT_WORK = 8'h0E;
  localparam logic [7:0] OPC_MUL_LIT = 8'h0D;
  localparam logic [7:0] OPC_BANK_LOAD = 8'h01;
  localparam logic [9:0] OPC_PTR_LOAD = 10'h3B8;
  localparam logic [5:0] OPC_OR_FILE = 6'h04;
  localparam logic [5:0] OPC_COPY = 6'h14;
  localparam logic [6:0] OPC_WORK_FILE = 7'h37;
  localparam logic [6:0] OPC_MUL_FILE = 7'h01;
  localparam logic [3:0] OPC_FULL_MOVE = 4'hC;
  localparam logic [1:0] PTR_COUNT = 2'h3;

  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_t;

  typedef enum logic [3:0] {
    OP_NOP, OP_OR_LIT, OP_OR_FILE, OP_PTR_LOAD, OP_COPY, OP_FULL_MOVE,
    OP_BANK_LOAD, OP_LIT_WORK, OP_WORK_FILE, OP_MUL_LIT, OP_MUL_FILE
  } op_t;

  function automatic logic is_work_addr(input logic [11:0] a);
    return a == WORK_ADDR;
  endfunction

endpackage
`default_nettype wire

// *** rtl/addr_if.sv ***
// carrier between the execute sequencer and its operand unit
`timescale 1ns/10ps
`default_nettype none
interface addr_if;
  logic [15:0] word;
  logic [3:0] bank_sel;
  logic [11:0] ptr2_base;
  logic ext_en;
  logic [7:0] w_val;
  logic [7:0] opnd;
  logic [11:0] file_addr;
  logic [15:0] product;
  modport unit (
    input word, bank_sel, ptr2_base, ext_en, w_val, opnd,
    output file_addr, product
  );
  modport core (
    output word, bank_sel, ptr2_base, ext_en, w_val, opnd,
    input file_addr, product
  );
endinterface
`default_nettype wire

// *** rtl/operand_unit.sv ***
// file address generation and unsigned 8x8 multiplier
`timescale 1ns/10ps
`default_nettype none
module operand_unit (
  addr_if.unit au
);
  logic [7:0] f;

  always_comb
  begin
    f = au.word[7:0];
    // RL3 bank or access
    if (au.word[8])
      au.file_addr = {au.bank_sel, f};
    // RL4 indexed literal offset
    else if (au.ext_en && f < exec_pkg::ACCESS_SPLIT)
      au.file_addr = 12'(au.ptr2_base + {4'h0, f});
    else if (f < exec_pkg::ACCESS_SPLIT)
      au.file_addr = {exec_pkg::ACCESS_LOW_BANK, f};
    else
      au.file_addr = {exec_pkg::ACCESS_HIGH_BANK, f};
  end

  // RL15 unsigned product
  assign au.product = {8'h00, au.w_val} * {8'h00, au.opnd};
endmodule
`default_nettype wire

// *** rtl/logic_move_multiply_exec.sv ***
// execute unit for OR, move, pointer load, bank load and multiply
// Functional notes
// RL1 - or literal into work: W|k to W, set N and Z, one cycle
// RL2 - or work with file: result to W if d=0, to file if d=1
// RL3 - access bit 0 uses access bank, 1 uses bank select register
// RL4 - extended set, a=0, f<=95: indexed literal offset via pointer 2
// RL5 - pointer load: 12-bit literal into pointer 0..2, two words, two cycles
// RL6 - pointer load writes high part first cycle, low byte second cycle
// RL7 - file copy to W (d=0) or back to file (d=1), set N and Z
// RL8 - full-space move: 12-bit source then 12-bit destination, 2 or 3 cycles
// RL9 - full move reads source first cycle, dummy, writes destination in Q4
// RL10 - software never targets program counter low or stack top bytes
// RL11 - full move may use W as source or destination, flags unchanged
// RL12 - bank select load keeps low nibble, bits 7:4 read zero
// RL13 - literal to work loads W in one cycle, flags unchanged
// RL14 - work to file stores W in one cycle, flags unchanged
// RL15 - multiply literal: W*k unsigned into product pair, W unchanged
// RL16 - multiply file: W*f unsigned into product pair, operands unchanged
// RL17 - multiplies touch no status flag
// RL18 - file copy reaches any byte of the selected 256-byte bank
// RL19 - decode Q1, read Q2, compute Q3, write Q4
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module logic_move_multiply_exec (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  output logic instr_ready,
  output logic [11:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  output logic flag_n,
  output logic flag_z
);

  typedef struct packed {
    exec_pkg::phase_t phase;
    logic second;
    exec_pkg::op_t op;
    logic [15:0] ir;
    logic [7:0] word2;
    logic [7:0] w;
    logic [3:0] bank_sel;
    logic [7:0] prod_low;
    logic [7:0] prod_high;
    logic [2:0][11:0] ptr;
    logic flag_n;
    logic flag_z;
    logic ext_en;
    logic [7:0] opnd;
    logic instr_ready;
    logic [11:0] mem_addr;
    logic mem_rd;
    logic mem_wr;
    logic [7:0] mem_wdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } state_t;

  state_t r;
  state_t next_r;
  addr_if au_bus ();
  logic [7:0] operand;
  logic [7:0] res;
  logic work_hit;
  logic [1:0] sel;

  function automatic exec_pkg::op_t decode_op(input logic [15:0] iw);
    if (iw[15:8] == exec_pkg::OPC_OR_LIT)
      return exec_pkg::OP_OR_LIT;
    else if (iw[15:8] == exec_pkg::OPC_LIT_WORK)
      return exec_pkg::OP_LIT_WORK;
    else if (iw[15:8] == exec_pkg::OPC_MUL_LIT)
      return exec_pkg::OP_MUL_LIT;
    else if (iw[15:8] == exec_pkg::OPC_BANK_LOAD)
      return exec_pkg::OP_BANK_LOAD;
    else if (iw[15:6] == exec_pkg::OPC_PTR_LOAD)
      return exec_pkg::OP_PTR_LOAD;
    else if (iw[15:10] == exec_pkg::OPC_OR_FILE)
      return exec_pkg::OP_OR_FILE;
    else if (iw[15:10] == exec_pkg::OPC_COPY)
      return exec_pkg::OP_COPY;
    else if (iw[15:9] == exec_pkg::OPC_WORK_FILE)
      return exec_pkg::OP_WORK_FILE;
    else if (iw[15:9] == exec_pkg::OPC_MUL_FILE)
      return exec_pkg::OP_MUL_FILE;
    else if (iw[15:12] == exec_pkg::OPC_FULL_MOVE)
      return exec_pkg::OP_FULL_MOVE;
    else
      return exec_pkg::OP_NOP;
  endfunction

  // the operand unit decodes the incoming word in Q1, the held word after
  assign au_bus.word = (r.phase == exec_pkg::PH_Q1) ? instr_word : r.ir;
  assign au_bus.bank_sel = r.bank_sel;
  assign au_bus.ptr2_base = r.ptr[2];
  assign au_bus.ext_en = r.ext_en;
  assign au_bus.w_val = r.w;
  assign au_bus.opnd = r.opnd;

  operand_unit u_operand (
    .au(au_bus)
  );

  assign work_hit = exec_pkg::is_work_addr(au_bus.file_addr);
  assign sel = r.ir[5:4];

  always_comb
  begin
    next_r = r;
    next_r.mem_rd = 1'h0;
    next_r.mem_wr = 1'h0;
    operand = 8'h00;
    res = 8'h00;
    unique case (r.phase)
      exec_pkg::PH_Q1:
      begin
        if (instr_valid && r.instr_ready)
        begin
          next_r.instr_ready = 1'h0;
          next_r.phase = exec_pkg::PH_Q2;
          if (!r.second)
          begin
            // RL19 decode in Q1
            next_r.ir = instr_word;
            next_r.op = decode_op(instr_word);
            next_r.mem_addr = au_bus.file_addr;
            if (decode_op(instr_word) == exec_pkg::OP_FULL_MOVE)
            begin
              // RL8 source address word
              next_r.mem_addr = instr_word[11:0];
              // RL11 W as source skips memory
              next_r.mem_rd = !exec_pkg::is_work_addr(instr_word[11:0]);
            end
            else if (decode_op(instr_word) == exec_pkg::OP_OR_FILE ||
                     decode_op(instr_word) == exec_pkg::OP_COPY ||
                     decode_op(instr_word) == exec_pkg::OP_MUL_FILE)
            begin
              // RL18 any byte of the chosen bank
              next_r.mem_rd = !work_hit;
            end
          end
          else
          begin
            next_r.word2 = instr_word[7:0];
            // RL8 destination address word
            if (r.op == exec_pkg::OP_FULL_MOVE)
              next_r.mem_addr = instr_word[11:0];
          end
        end
      end
      exec_pkg::PH_Q2:
      begin
        // RL9 second cycle Q2 is idle, no dummy read
        next_r.phase = exec_pkg::PH_Q3;
      end
      exec_pkg::PH_Q3:
      begin
        next_r.phase = exec_pkg::PH_Q4;
        if (r.op == exec_pkg::OP_FULL_MOVE)
        begin
          if (!r.second)
          begin
            // RL9 source read in first cycle
            if (exec_pkg::is_work_addr(r.mem_addr))
              next_r.opnd = r.w;
            else
              next_r.opnd = mem_rdata;
          end
          else if (!exec_pkg::is_work_addr(r.mem_addr))
          begin
            // RL9 destination write lands in Q4
            next_r.mem_wr = 1'h1;
            next_r.mem_wdata = r.opnd;
          end
        end
        else if (!r.second)
        begin
          // RL19 compute in Q3
          if (r.op == exec_pkg::OP_OR_FILE || r.op == exec_pkg::OP_COPY ||
              r.op == exec_pkg::OP_MUL_FILE)
            operand = work_hit ? r.w : mem_rdata;
          else
            operand = r.ir[7:0];
          unique case (r.op)
            exec_pkg::OP_OR_LIT: res = r.w | operand;
            exec_pkg::OP_OR_FILE: res = r.w | operand;
            exec_pkg::OP_WORK_FILE: res = r.w;
            default: res = operand;
          endcase
          next_r.opnd = res;
          // RL2 d=1 writes the file register
          if ((r.op == exec_pkg::OP_OR_FILE || r.op == exec_pkg::OP_COPY) &&
              r.ir[9] && !work_hit)
          begin
            next_r.mem_wr = 1'h1;
            next_r.mem_wdata = res;
          end
          // RL14 W stored into the file
          if (r.op == exec_pkg::OP_WORK_FILE && !work_hit)
          begin
            next_r.mem_wr = 1'h1;
            next_r.mem_wdata = res;
          end
        end
      end
      exec_pkg::PH_Q4:
      begin
        next_r.phase = exec_pkg::PH_Q1;
        next_r.instr_ready = 1'h1;
        next_r.second = 1'h0;
        unique case (r.op)
          exec_pkg::OP_OR_LIT, exec_pkg::OP_OR_FILE, exec_pkg::OP_COPY:
          begin
            // RL1 literal result to W
            // RL7 copy to W or back to itself
            if (r.op == exec_pkg::OP_OR_LIT || !r.ir[9] || work_hit)
              next_r.w = r.opnd;
            next_r.flag_n = r.opnd[7];
            next_r.flag_z = (r.opnd == 8'h00);
          end
          exec_pkg::OP_LIT_WORK:
          begin
            // RL13 literal to W, no flags
            next_r.w = r.opnd;
          end
          exec_pkg::OP_WORK_FILE:
          begin
            if (work_hit)
              next_r.w = r.opnd;
          end
          exec_pkg::OP_BANK_LOAD:
          begin
            // RL12 upper nibble dropped
            next_r.bank_sel = r.opnd[3:0];
          end
          exec_pkg::OP_MUL_LIT, exec_pkg::OP_MUL_FILE:
          begin
            // RL16 file operand product
            // RL17 flags left alone
            next_r.prod_high = au_bus.product[15:8];
            next_r.prod_low = au_bus.product[7:0];
          end
          exec_pkg::OP_PTR_LOAD:
          begin
            // RL5 selector above 2 loads nothing
            if (sel != exec_pkg::PTR_COUNT)
            begin
              // RL6 high part first, low byte second
              if (!r.second)
                next_r.ptr[sel][11:8] = r.ir[3:0];
              else
                next_r.ptr[sel][7:0] = r.word2;
            end
            next_r.second = !r.second;
          end
          exec_pkg::OP_FULL_MOVE:
          begin
            // RL11 W destination, flags unchanged
            if (r.second && exec_pkg::is_work_addr(r.mem_addr))
              next_r.w = r.opnd;
            next_r.second = !r.second;
          end
          exec_pkg::OP_NOP: next_r.second = 1'h0;
        endcase
      end
    endcase

    // bus slave: answer during the access phase, zero wait states
    if (psel && !penable && !r.pready)
    begin
      next_r.pready = 1'h1;
      next_r.pslverr = 1'h0;
      next_r.prdata = 32'h0000_0000;
      unique case (paddr)
        exec_pkg::OFS_WORK: next_r.prdata[7:0] = r.w;
        exec_pkg::OFS_BANK: next_r.prdata[3:0] = r.bank_sel;
        exec_pkg::OFS_PROD_LOW: next_r.prdata[7:0] = r.prod_low;
        exec_pkg::OFS_PROD_HIGH: next_r.prdata[7:0] = r.prod_high;
        exec_pkg::OFS_PTR0: next_r.prdata[11:0] = r.ptr[0];
        exec_pkg::OFS_PTR1: next_r.prdata[11:0] = r.ptr[1];
        exec_pkg::OFS_PTR2: next_r.prdata[11:0] = r.ptr[2];
        exec_pkg::OFS_STATUS:
        begin
          next_r.prdata[exec_pkg::STATUS_Z_BIT] = r.flag_z;
          next_r.prdata[exec_pkg::STATUS_N_BIT] = r.flag_n;
        end
        exec_pkg::OFS_CTRL: next_r.prdata[exec_pkg::CTRL_EXT_BIT] = r.ext_en;
        exec_pkg::OFS_EXEC: next_r.prdata[7:0] = {r.phase, r.second, 1'h0, r.op};
        default: next_r.pslverr = 1'h1;
      endcase
    end
    else if (psel && penable && r.pready)
    begin
      next_r.pready = 1'h0;
      next_r.pslverr = 1'h0;
      // a bus write lands after the core update of the same edge
      if (pwrite)
      begin
        unique case (paddr)
          exec_pkg::OFS_WORK: next_r.w = pwdata[7:0];
          exec_pkg::OFS_BANK: next_r.bank_sel = pwdata[3:0];
          exec_pkg::OFS_PROD_LOW: next_r.prod_low = pwdata[7:0];
          exec_pkg::OFS_PROD_HIGH: next_r.prod_high = pwdata[7:0];
          exec_pkg::OFS_PTR0: next_r.ptr[0] = pwdata[11:0];
          exec_pkg::OFS_PTR1: next_r.ptr[1] = pwdata[11:0];
          exec_pkg::OFS_PTR2: next_r.ptr[2] = pwdata[11:0];
          exec_pkg::OFS_STATUS:
          begin
            next_r.flag_z = pwdata[exec_pkg::STATUS_Z_BIT];
            next_r.flag_n = pwdata[exec_pkg::STATUS_N_BIT];
          end
          exec_pkg::OFS_CTRL: next_r.ext_en = pwdata[exec_pkg::CTRL_EXT_BIT];
          default: next_r.pslverr = 1'h0;
        endcase
      end
    end
    else if (!psel)
    begin
      next_r.pready = 1'h0;
      next_r.pslverr = 1'h0;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      r <= '0;
      r.phase <= exec_pkg::PH_Q1;
      r.op <= exec_pkg::OP_NOP;
      r.w <= exec_pkg::WORK_RST;
      r.bank_sel <= exec_pkg::BANK_RST;
      r.prod_low <= exec_pkg::PROD_RST;
      r.prod_high <= exec_pkg::PROD_RST;
      r.ptr <= {3{exec_pkg::PTR_RST}};
      r.ext_en <= exec_pkg::EXT_RST;
      r.instr_ready <= 1'h1;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign instr_ready = r.instr_ready;
  assign mem_addr = r.mem_addr;
  assign mem_rd = r.mem_rd;
  assign mem_wr = r.mem_wr;
  assign mem_wdata = r.mem_wdata;
  assign flag_n = r.flag_n;
  assign flag_z = r.flag_z;
endmodule
`default_nettype wire

// *** verif/logic_move_multiply_exec_props.sv ***
// port-level assertions for the execute block
`timescale 1ns/10ps
`default_nettype none
module logic_move_multiply_exec_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic instr_ready,
  input wire logic [11:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic flag_n,
  input wire logic flag_z
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_take;
    instr_valid && instr_ready;
  endsequence
  sequence s_busy;
    !instr_ready [*3] ##1 instr_ready;
  endsequence
  a_cycle_four_phase: assert property (s_take |=> s_busy)
    else $error("instruction cycle is not four clocks");
  a_read_in_q2: assert property (mem_rd |-> $past(instr_valid && instr_ready))
    else $error("memory read outside the second phase");
  a_read_single: assert property (mem_rd |=> !mem_rd)
    else $error("memory read strobe longer than one clock");
  a_write_in_q4: assert property (mem_wr |-> $past(instr_valid && instr_ready, 3))
    else $error("memory write outside the last phase");
  a_flags_commit: assert property (($changed(flag_n) || $changed(flag_z)) |-> $past(instr_valid && instr_ready, 4) || $past(psel && penable && pwrite))
    else $error("flags changed at an unexpected clock");
  a_ready_holds: assert property (instr_ready && !instr_valid |=> instr_ready)
    else $error("ready dropped without a word taken");
  a_bus_zero_wait: assert property (psel && !penable |=> pready)
    else $error("bus answer not in the access cycle");
  a_bus_ready_once: assert property (pready |=> !pready)
    else $error("bus ready longer than one clock");
  a_bus_err_timed: assert property (pslverr |-> pready && psel && penable)
    else $error("bus error outside an access cycle");
endmodule
bind logic_move_multiply_exec logic_move_multiply_exec_props u_props (
  .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .instr_valid, .instr_word, .instr_ready, .mem_addr, .mem_rd,
  .mem_wr, .mem_wdata, .mem_rdata, .flag_n, .flag_z
);
`default_nettype wire

// *** verif/data_mem.sv ***
// behavioural data memory on the far side of the execute block
`timescale 1ns/10ps
`default_nettype none
module data_mem (
  input wire logic clk,
  input wire logic [11:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] ram [0:4095];
  initial
  begin
    mem_rdata = 8'h00;
    for (int i = 0; i < 4096; i++)
      ram[i] = 8'hA5;
  end
  // data is good only the clock after a read; it flips otherwise so a
  // late sample cannot match by luck
  always @(posedge clk)
  begin
    if (mem_rd)
      mem_rdata <= ram[mem_addr];
    else
      mem_rdata <= ~mem_rdata;
    if (mem_wr)
      ram[mem_addr] <= mem_wdata;
  end
endmodule
`default_nettype wire

// *** verif/logic_move_multiply_exec_tb.sv ***
// self-checking bench for the execute block
`timescale 1ns/10ps
`default_nettype none
module logic_move_multiply_exec_tb;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, rerr;
  logic instr_valid, instr_ready, mem_rd, mem_wr, flag_n, flag_z;
  logic [7:0] paddr, mem_wdata, mem_rdata;
  logic [31:0] pwdata, prdata, rdat;
  logic [15:0] instr_word;
  logic [11:0] mem_addr;
  int errors = 0, checks = 0, cyc = 0;
  logic_move_multiply_exec DUT (.clk, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .instr_valid, .instr_word,
    .instr_ready, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata,
    .flag_n, .flag_z);
  data_mem mem (.clk, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata);
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic test_done;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      errors++;
      test_done();
    end
  end
  task automatic ck(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n == 20) errors++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    ck($sformatf("reg %h", a), e, rdat);
  endtask
  task automatic fl(input logic n, input logic z);
    ck("flags", {30'h0, n, z}, {30'h0, flag_n, flag_z});
  endtask
  task automatic mm(input logic [11:0] a, input logic [7:0] e);
    ck("mem", {24'h0, e}, {24'h0, mem.ram[a]});
  endtask
  // one program word: wait for the take, then for the next first phase
  task automatic op(input logic [15:0] w);
    int n;
    instr_valid <= 1'b1;
    instr_word <= w;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (instr_ready !== 1'b1 && n < 50);
    instr_valid <= 1'b0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (instr_ready !== 1'b1 && n < 100);
    if (n >= 100) errors++;
  endtask
  task automatic t_reset;
    for (int i = 0; i < 10; i++)
      rd(8'(4 * i), 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    ck("unmapped", 32'h1, {31'h0, rerr});
  endtask
  task automatic t_literal;
    apb(1'b1, 8'h1C, 32'h3);
    op(16'h0E5A);
    rd(8'h00, 32'h5A);
    fl(1'b1, 1'b1);
    op(16'h0E9A);
    op(16'h0935);
    rd(8'h00, 32'hBF);
    fl(1'b1, 1'b0);
    op(16'h0E00);
    op(16'h0900);
    fl(1'b0, 1'b1);
  endtask
  task automatic t_bank_or;
    op(16'h01F5);
    rd(8'h04, 32'h5);
    mem.ram[12'h520] = 8'h13;
    mem.ram[12'h521] = 8'h04;
    op(16'h0E91);
    op(16'h1320);
    mm(12'h520, 8'h93);
    rd(8'h00, 32'h91);
    op(16'h1121);
    rd(8'h00, 32'h95);
    fl(1'b1, 1'b0);
  endtask
  task automatic t_access;
    mem.ram[12'h030] = 8'h22;
    mem.ram[12'hF80] = 8'h80;
    mem.ram[12'h5FF] = 8'h00;
    op(16'h5030);
    rd(8'h00, 32'h22);
    op(16'h5080);
    rd(8'h00, 32'h80);
    fl(1'b1, 1'b0);
    op(16'h53FF);
    rd(8'h00, 32'h80);
    fl(1'b0, 1'b1);
  endtask
  task automatic t_pointer;
    logic [11:0] k [3] = '{12'h3AB, 12'hFFF, 12'h5C1};
    for (int s = 0; s < 3; s++)
    begin
      op({8'hEE, 2'h0, 2'(s), k[s][11:8]});
      rd(8'h10 + 8'(4 * s), {20'h0, k[s][11:8], 8'h00});
      rd(8'h24, {24'h0, 2'h0, 1'b1, 1'b0, exec_pkg::OP_PTR_LOAD});
      op({8'hF0, k[s][7:0]});
      rd(8'h10 + 8'(4 * s), {20'h0, k[s]});
    end
  endtask
  task automatic t_indexed;
    apb(1'b1, 8'h20, 32'h1);
    op(16'hEE21);
    op(16'hF000);
    mem.ram[12'h15F] = 8'h5A;
    mem.ram[12'hF60] = 8'h3C;
    op(16'h505F);
    rd(8'h00, 32'h5A);
    op(16'h5060);
    rd(8'h00, 32'h3C);
    apb(1'b1, 8'h20, 32'h0);
  endtask
  // destinations avoid program counter low and stack top bytes
  task automatic t_full_move;
    apb(1'b1, 8'h1C, 32'h3);
    mem.ram[12'h123] = 8'h33;
    mem.ram[12'hFFF] = 8'h66;
    op(16'hC123);
    op(16'hF456);
    mm(12'h456, 8'h33);
    op(16'hCFFF);
    op(16'hFFE8);
    rd(8'h00, 32'h66);
    op(16'h0E77);
    op(16'hCFE8);
    op(16'hF000);
    mm(12'h000, 8'h77);
    fl(1'b1, 1'b1);
  endtask
  task automatic t_store_mul;
    op(16'h0E4F);
    op(16'h6F10);
    mm(12'h510, 8'h4F);
    op(16'h0EE2);
    op(16'h0DC4);
    rd(8'h0C, 32'hAD);
    rd(8'h08, 32'h08);
    rd(8'h00, 32'hE2);
    mem.ram[12'h511] = 8'hB5;
    op(16'h0EC4);
    op(16'h0311);
    rd(8'h0C, 32'h8A);
    rd(8'h08, 32'h94);
    mm(12'h511, 8'hB5);
    fl(1'b1, 1'b1);
    apb(1'b1, 8'h1C, 32'h0);
    op(16'h0D00);
    fl(1'b0, 1'b0);
  endtask
  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    instr_valid = 1'b0;
    instr_word = 16'h0000;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_literal();
    t_bank_or();
    t_access();
    t_pointer();
    t_indexed();
    t_full_move();
    t_store_mul();
    test_done();
  end
endmodule
`default_nettype wire
